// >>> rtl/rfcmd_pkg.sv
// constants and field layouts shared by the block read/write command logic
package rfcmd_pkg;
  // ==========================================================
  // request and response fields
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_WRITE = 8'h21;
  localparam int FLG_PROT_EXT = 3;
  localparam int FLG_ADDR = 5;
  localparam int FLG_OPTION = 6;
  localparam int UID_POS = 2;
  localparam int MAX_REQ = 18;
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [7:0] RSP_ERR = 8'h01;
  localparam logic [7:0] ERR_GENERIC = 8'h0f;
  localparam logic [7:0] ERR_NO_BLOCK = 8'h10;
  localparam logic [7:0] ERR_LOCKED = 8'h12;
  localparam logic [7:0] ERR_PROG = 8'h13;
  localparam logic [7:0] ERR_RD_PROT = 8'h15;
  // ==========================================================
  // sector security status byte
  localparam int SEC_LOCK = 0;
  localparam int SEC_RW_LSB = 1;
  localparam int SEC_PWD_LSB = 3;
  localparam logic [1:0] SEC_RD_PROT = 2'h3;
  localparam int SECT_SH = 5;
  // ==========================================================
  // crc16, reflected, residue over frame plus its crc
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hf0b8;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int T1_NOM_NS = 320900;
  localparam int WT_PERIOD_NS = 302000;
  localparam int WT_PERIODS = 18;
  localparam int RESP_DELAY_CYC = T1_NOM_NS / CLK_PERIOD_NS;
  localparam int PROG_WAIT_CYC = (T1_NOM_NS + WT_PERIODS * WT_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int CNT_W = 21;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_UID_LO = 8'h0c;
  localparam logic [7:0] ADDR_UID_HI = 8'h10;
  localparam logic [7:0] ADDR_SEC = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  localparam int CTRL_WIP = 0;
  localparam int CTRL_FAIL = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int EV_READ = 0;
  localparam int EV_WRITE = 1;
  localparam int EV_ERROR = 2;
  localparam int EV_DROP = 3;
  localparam int NUM_EV = 4;
  // arbitrary neutral uid
  localparam logic [63:0] UID_RST = 64'h0000_0000_0000_0001;
endpackage

// >>> rtl/crc_if.sv
// byte-wide link between the command logic and its crc engine
`timescale 1ns/10ps
interface crc_if;
  logic init;
  logic feed;
  logic [7:0] data;
  logic [15:0] crc;
  modport engine (input init, input feed, input data, output crc);
  modport user (output init, output feed, output data, input crc);
endinterface

// >>> rtl/crc16_engine.sv
// running crc16 over a byte stream, one byte per feed
`timescale 1ns/10ps
module crc16_engine
  import rfcmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  crc_if.engine port
);
  typedef struct packed {
    logic [15:0] crc;
  } crc_state_t;

  crc_state_t st_reg;
  crc_state_t st_next;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  always_comb begin
    st_next = st_reg;
    if (port.init) begin
      st_next.crc = CRC_INIT;
    end else if (port.feed) begin
      st_next.crc = crc_byte(st_reg.crc, port.data);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign port.crc = st_reg.crc;
endmodule

// >>> rtl/rf_block_cmd.sv
// single-block read and write command interpreter with activity pin
`timescale 1ns/10ps
// Operation
// - valid read returns the whole 32-bit content of the addressed block
// - protocol extension flag must be 1, else an error response
// - read request: flags, 20h, optional uid, block number, crc
// - read reply: flags, security byte only with option flag, four data bytes, crc
// - security byte: bit0 lock, bits 1-2 read/write protection, 3-4 password
// - read errors: 10h missing block, 15h read-protected block
// - error reply: flags with error bit, error code, crc
// - busy mode: pin low from request start to end of reply
// - write-in-progress mode: pin released during reads
// - valid write programs the block and reports success or failure
// - write cycle lasts nominal reply delay plus 18 periods of 302 us
// - write request: flags, 21h, optional uid, block, 32 data bits, crc
// - write reply only after programming; success holds flags and crc
// - write errors: 0Fh generic, 10h missing, 12h locked, 13h failed
// - busy mode: pin low from write start to end of reply
// - write-in-progress mode: pin low from request end to reply start
module rf_block_cmd
  import rfcmd_pkg::*;
#(
  parameter int NUM_BLOCKS = 64,
  parameter int RESP_CYC = RESP_DELAY_CYC,
  parameter int PROG_CYC = PROG_WAIT_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ_O,
  input wire logic RF_CLK_I,
  input wire logic RX_SOF_I,
  input wire logic RX_EOF_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_BYTE_I,
  output logic TX_VALID_O,
  output logic TX_LAST_O,
  output logic [7:0] TX_BYTE_O,
  input wire logic ACT_PIN_I,
  output logic ACT_PIN_O,
  output logic ACT_PIN_OE_O
);
  localparam int BW = $clog2(NUM_BLOCKS);
  localparam int SECW = 8 * (NUM_BLOCKS >> SECT_SH);

  typedef enum logic [1:0] {IDLE, RECV, WAIT, SEND} phase_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [1:0] ctrl;
    logic [NUM_EV-1:0] irq_st;
    logic [NUM_EV-1:0] irq_mask;
    logic irq;
    logic [63:0] uid;
    logic [SECW-1:0] sec;
    logic [2:0] lclk;
    logic [10:0] rx1;
    logic [10:0] rx2;
    logic [1:0] pin_s;
    phase_t st;
    logic [MAX_REQ-1:0][7:0] rxb;
    logic [4:0] rxn;
    logic [CNT_W-1:0] cnt;
    logic prog;
    logic [5:0][7:0] txb;
    logic [2:0] txl;
    logic [3:0] txi;
    logic tx_v;
    logic tx_last;
    logic [7:0] tx_d;
    logic pin_oe;
    logic pin_lvl;
    logic c_init;
    logic c_feed;
    logic [7:0] c_data;
    logic [NUM_BLOCKS-1:0][31:0] mem;
  } state_t;

  state_t r;
  state_t n;
  crc_if cbus();

  crc16_engine u_crc (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .port(cbus.engine)
  );

  assign cbus.init = r.c_init;
  assign cbus.feed = r.c_feed;
  assign cbus.data = r.c_data;

  // ==========================================================
  // next state
  always_comb begin
    logic rise;
    logic sof;
    logic eof;
    logic bv;
    logic [7:0] fl;
    logic [7:0] cmd;
    logic [7:0] code;
    logic [7:0] secb;
    logic [4:0] p;
    logic [15:0] blk;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [31:0] m;
    logic [31:0] clr;
    logic [63:0] uid_rx;
    logic rdc;
    logic wrc;
    logic hit;
    logic bad;
    logic prog;
    logic [NUM_EV-1:0] ev;
    n = r;
    rise = r.lclk[1] & ~r.lclk[2];
    sof = rise & r.rx2[10];
    eof = rise & r.rx2[9];
    bv = rise & r.rx2[8];
    fl = r.rxb[0];
    cmd = r.rxb[1];
    code = 8'h00;
    prog = 1'b0;
    clr = 32'h0;
    ev = '0;
    m = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    // link input synchronisers
    n.lclk = {r.lclk[1:0], RF_CLK_I};
    n.rx1 = {RX_SOF_I, RX_EOF_I, RX_VALID_I, RX_BYTE_I};
    n.rx2 = r.rx1;
    n.pin_s = {r.pin_s[0], ACT_PIN_I};
    n.c_init = 1'b0;
    n.c_feed = 1'b0;
    n.pin_lvl = 1'b0;

    // request decode
    p = fl[FLG_ADDR] ? 5'd10 : 5'd2;
    blk = {r.rxb[p + 1], r.rxb[p]};
    wd = {r.rxb[p + 5], r.rxb[p + 4], r.rxb[p + 3], r.rxb[p + 2]};
    for (int i = 0; i < 8; i++) begin
      uid_rx[i*8 +: 8] = r.rxb[UID_POS + i];
    end
    rdc = (cmd == CMD_READ);
    wrc = (cmd == CMD_WRITE);
    hit = (blk < 16'(NUM_BLOCKS));
    secb = r.sec[8 * int'(blk[BW-1:SECT_SH]) +: 8];
    rd = r.mem[blk[BW-1:0]];
    bad = (r.rxn < 5'd4) || (!rdc && !wrc) || (cbus.crc != CRC_RESIDUE);
    bad = bad || (r.rxn != p + (wrc ? 5'd8 : 5'd4));
    bad = bad || (fl[FLG_ADDR] && uid_rx != r.uid);
    if (!fl[FLG_PROT_EXT]) begin
      code = ERR_GENERIC;
    end else if (!hit) begin
      code = ERR_NO_BLOCK;
    end else if (rdc && secb[SEC_RW_LSB +: 2] == SEC_RD_PROT) begin
      code = ERR_RD_PROT;
    end else if (wrc && secb[SEC_LOCK]) begin
      code = ERR_LOCKED;
    end else if (wrc) begin
      prog = 1'b1;
      if (r.ctrl[CTRL_FAIL]) begin
        code = ERR_PROG;
      end
    end

    // ==========================================================
    // command sequencer
    case (r.st)
      IDLE: begin
        if (sof) begin
          n.st = RECV;
          n.rxn = 5'd0;
          n.c_init = 1'b1;
          n.pin_oe = !r.ctrl[CTRL_WIP];
        end
      end
      RECV: begin
        if (sof) begin
          n.rxn = 5'd0;
          n.c_init = 1'b1;
          n.pin_oe = !r.ctrl[CTRL_WIP];
        end else if (bv) begin
          if (r.rxn < 5'(MAX_REQ)) begin
            n.rxb[r.rxn] = r.rx2[7:0];
          end
          if (r.rxn != 5'h1f) begin
            n.rxn = r.rxn + 5'd1;
          end
          n.c_feed = 1'b1;
          n.c_data = r.rx2[7:0];
        end else if (eof) begin
          if (bad) begin
            n.st = IDLE;
            n.pin_oe = 1'b0;
            ev[EV_DROP] = 1'b1;
          end else begin
            n.st = WAIT;
            n.prog = prog;
            n.c_init = 1'b1;
            n.txb = '0;
            if (code != 8'h00) begin
              n.txb[0] = RSP_ERR;
              n.txb[1] = code;
              n.txl = 3'd2;
            end else if (rdc && fl[FLG_OPTION]) begin
              n.txb[0] = RSP_OK;
              n.txb[1] = secb;
              n.txb[5:2] = {rd[31:24], rd[23:16], rd[15:8], rd[7:0]};
              n.txl = 3'd6;
            end else if (rdc) begin
              n.txb[0] = RSP_OK;
              n.txb[4:1] = {rd[31:24], rd[23:16], rd[15:8], rd[7:0]};
              n.txl = 3'd5;
            end else begin
              n.txb[0] = RSP_OK;
              n.txl = 3'd1;
            end
            if (prog && code == 8'h00) begin
              n.mem[blk[BW-1:0]] = wd;
            end
            // programming waits the full write cycle
            n.cnt = prog ? CNT_W'(PROG_CYC - 1) : CNT_W'(RESP_CYC - 1);
            if (prog && r.ctrl[CTRL_WIP]) begin
              n.pin_oe = 1'b1;
            end
          end
        end
      end
      // link input ignored here: no modulation expected
      WAIT: begin
        if (r.cnt != '0) begin
          n.cnt = r.cnt - CNT_W'(1);
        end else begin
          n.st = SEND;
          n.txi = 4'd0;
          if (r.ctrl[CTRL_WIP]) begin
            n.pin_oe = 1'b0;
          end
        end
      end
      SEND: begin
        if (rise) begin
          n.txi = r.txi + 4'd1;
          n.tx_v = 1'b1;
          n.tx_last = 1'b0;
          if (r.txi < {1'b0, r.txl}) begin
            n.tx_d = r.txb[r.txi[2:0]];
            n.c_feed = 1'b1;
            n.c_data = r.txb[r.txi[2:0]];
          end else if (r.txi == {1'b0, r.txl}) begin
            n.tx_d = ~cbus.crc[7:0];
          end else if (r.txi == {1'b0, r.txl} + 4'd1) begin
            n.tx_d = ~cbus.crc[15:8];
            n.tx_last = 1'b1;
          end else begin
            n.tx_v = 1'b0;
            n.tx_d = 8'h00;
            n.st = IDLE;
            n.pin_oe = 1'b0;
            ev[EV_READ] = rdc;
            ev[EV_WRITE] = wrc;
            ev[EV_ERROR] = r.txb[0][0];
          end
        end
      end
      default: begin
        n.st = IDLE;
      end
    endcase

    // ==========================================================
    // wishbone slave, one wait state
    n.ack = 1'b0;
    if (WB_CYC_I && WB_STB_I && !r.ack) begin
      n.ack = 1'b1;
      n.dat = 32'h0;
      if (WB_WE_I) begin
        if (WB_ADR_I == ADDR_CTRL) begin
          n.ctrl = (r.ctrl & ~m[1:0]) | (WB_DAT_I[1:0] & m[1:0]);
        end else if (WB_ADR_I == ADDR_STATUS) begin
          clr = WB_DAT_I & m;
        end else if (WB_ADR_I == ADDR_MASK) begin
          n.irq_mask = (r.irq_mask & ~m[NUM_EV-1:0]) | (WB_DAT_I[NUM_EV-1:0] & m[NUM_EV-1:0]);
        end else if (WB_ADR_I == ADDR_UID_LO) begin
          n.uid[31:0] = (r.uid[31:0] & ~m) | (WB_DAT_I & m);
        end else if (WB_ADR_I == ADDR_UID_HI) begin
          n.uid[63:32] = (r.uid[63:32] & ~m) | (WB_DAT_I & m);
        end else if (WB_ADR_I == ADDR_SEC) begin
          n.sec = (r.sec & ~m[SECW-1:0]) | (WB_DAT_I[SECW-1:0] & m[SECW-1:0]);
        end
      end else begin
        if (WB_ADR_I == ADDR_CTRL) begin
          n.dat = 32'(r.ctrl);
        end else if (WB_ADR_I == ADDR_STATUS) begin
          n.dat = 32'(r.irq_st);
        end else if (WB_ADR_I == ADDR_MASK) begin
          n.dat = 32'(r.irq_mask);
        end else if (WB_ADR_I == ADDR_UID_LO) begin
          n.dat = r.uid[31:0];
        end else if (WB_ADR_I == ADDR_UID_HI) begin
          n.dat = r.uid[63:32];
        end else if (WB_ADR_I == ADDR_SEC) begin
          n.dat = 32'(r.sec);
        end else if (WB_ADR_I == ADDR_STATE) begin
          n.dat = 32'({r.pin_s[1], r.pin_oe, r.st});
        end
      end
    end

    // sticky events: a new event wins over a clear
    n.irq_st = (r.irq_st & ~clr[NUM_EV-1:0]) | ev;
    n.irq = |(r.irq_st & r.irq_mask);
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r <= '0;
      r.uid <= UID_RST;
      r.ctrl <= CTRL_RST;
    end else begin
      r <= n;
    end
  end

  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.dat;
  assign IRQ_O = r.irq;
  assign TX_VALID_O = r.tx_v;
  assign TX_LAST_O = r.tx_last;
  assign TX_BYTE_O = r.tx_d;
  assign ACT_PIN_O = r.pin_lvl;
  assign ACT_PIN_OE_O = r.pin_oe;

  // ==========================================================
  // checks
  logic wip_m;
  logic rise_h;
  assign wip_m = r.ctrl[CTRL_WIP];
  assign rise_h = r.lclk[1] & ~r.lclk[2];

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_sof_taken;
    r.st == IDLE && rise_h && r.rx2[10] && !wip_m;
  endsequence

  sequence s_busy_low;
    r.pin_oe && r.st == RECV;
  endsequence

  property p_busy_on;
    s_sof_taken |=> s_busy_low;
  endproperty
  a_busy_on: assert property (p_busy_on)
    else $error("busy pin not driven at request start");

  property p_busy_hold;
    !wip_m && r.pin_oe && r.st != IDLE |=> r.pin_oe || r.st == IDLE || wip_m;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy pin released before end of reply");

  property p_wip_prog;
    wip_m && $stable(wip_m) && r.pin_oe |-> r.st == WAIT && r.prog;
  endproperty
  a_wip_prog: assert property (p_wip_prog)
    else $error("wip pin driven outside programming");

  property p_wip_on;
    $rose(r.st == WAIT) && r.prog && $past(wip_m) |-> r.pin_oe;
  endproperty
  a_wip_on: assert property (p_wip_on)
    else $error("wip pin not driven during programming");

  property p_prog_len;
    $rose(r.st == WAIT) && r.prog |-> r.cnt == CNT_W'(PROG_CYC - 1);
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("write cycle length wrong");

  property p_wait_count;
    r.st == WAIT && r.cnt != '0 |=> r.st == WAIT && r.cnt == $past(r.cnt) - 1;
  endproperty
  a_wait_count: assert property (p_wait_count)
    else $error("reply started before wait expired");

  property p_ext_err;
    $rose(r.st == WAIT) && !r.rxb[0][FLG_PROT_EXT]
      |-> r.txb[0] == RSP_ERR && r.txb[1] == ERR_GENERIC && r.txl == 3'd2;
  endproperty
  a_ext_err: assert property (p_ext_err)
    else $error("missing extension flag not answered with error");

  property p_rd_len;
    $rose(r.st == WAIT) && r.rxb[1] == CMD_READ && r.txb[0] == RSP_OK
      |-> r.txl == (r.rxb[0][FLG_OPTION] ? 3'd6 : 3'd5);
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read reply length wrong");

  property p_wr_ok;
    $rose(r.st == WAIT) && r.rxb[1] == CMD_WRITE && r.txb[0] == RSP_OK
      |-> r.txl == 3'd1 && r.prog;
  endproperty
  a_wr_ok: assert property (p_wr_ok)
    else $error("write success reply malformed");
endmodule

// >>> dv/rf_reader_model.sv
// reader-side model: sends request frames over the link and gathers replies
`timescale 1ns/10ps
module rf_reader_model (
  output logic lclk_o,
  output logic sof_o,
  output logic eof_o,
  output logic valid_o,
  output logic [7:0] byte_o,
  input wire logic tx_valid_i,
  input wire logic tx_last_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic pin_oe_i
);
  logic [7:0] req_q[$];
  logic [7:0] rsp_q[$];
  logic [4:0] pin_seen;
  logic [1:0] last_seen;
  int gap;
  logic run = 1'b0;
  initial begin
    lclk_o = 1'b0;
    sof_o = 1'b0;
    eof_o = 1'b0;
    valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // link clock runs only inside an exchange, parks low
  always begin
    #32;
    if (run || lclk_o) lclk_o <= ~lclk_o;
  end
  task automatic xfer();
    int n;
    int lasts;
    logic seen;
    rsp_q.delete();
    pin_seen = 5'b00100;
    gap = 0;
    lasts = 0;
    seen = 1'b0;
    n = 0;
    run = 1'b1;
    @(negedge lclk_o);
    sof_o <= 1'b1;
    foreach (req_q[i]) begin
      @(negedge lclk_o);
      sof_o <= 1'b0;
      valid_o <= 1'b1;
      byte_o <= req_q[i];
    end
    @(negedge lclk_o);
    valid_o <= 1'b0;
    byte_o <= ~byte_o;
    eof_o <= 1'b1;
    pin_seen[4] = pin_oe_i;
    @(negedge lclk_o);
    eof_o <= 1'b0;
    // stays silent until the reply is over
    while (n < 300) begin
      @(negedge lclk_o);
      n++;
      if (tx_valid_i === 1'b1) begin
        rsp_q.push_back(tx_byte_i);
        seen = 1'b1;
        pin_seen[2] = pin_seen[2] & pin_oe_i;
        pin_seen[1] = pin_seen[1] | pin_oe_i;
        if (tx_last_i === 1'b1) lasts++;
        last_seen[1] = tx_last_i;
      end else if (seen) begin
        break;
      end else begin
        pin_seen[3] = pin_seen[3] | pin_oe_i;
        gap++;
      end
    end
    pin_seen[0] = pin_oe_i;
    last_seen[0] = (lasts == 1);
    run = 1'b0;
  endtask
endmodule

// >>> dv/rf_block_cmd_bench.sv
// self-checking bench for the block read/write command interpreter
`timescale 1ns/10ps
module rf_block_cmd_bench;
  import rfcmd_pkg::*;
  localparam int RESP_T = 40;
  localparam int PROG_T = 200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat;
  logic ack, irq, lclk, sof, eof, rvalid, tvalid, tlast, pin_o, pin_oe, pin_lvl;
  logic [7:0] rbyte, tbyte;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] mem [64];
  logic [7:0] sec [2];
  logic [63:0] uid_v;
  logic [1:0] ctrl_v = 2'h0;
  logic [3:0] mask_v = 4'h0;
  logic [31:0] rd;
  int blk;
  logic [31:0] d;
  logic [7:0] ra [8] = '{ADDR_CTRL, ADDR_STATUS, ADDR_MASK, ADDR_UID_LO, ADDR_UID_HI,
                         ADDR_SEC, ADDR_STATE, 8'h40};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h8, 32'h0};
  always #2.5 clk = ~clk;
  // open-drain pin with pull-up
  assign pin_lvl = pin_oe ? pin_o : 1'b1;
  rf_block_cmd #(.NUM_BLOCKS(64), .RESP_CYC(RESP_T), .PROG_CYC(PROG_T)) u_rf_block_cmd (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
    .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .IRQ_O(irq), .RF_CLK_I(lclk), .RX_SOF_I(sof), .RX_EOF_I(eof), .RX_VALID_I(rvalid),
    .RX_BYTE_I(rbyte), .TX_VALID_O(tvalid), .TX_LAST_O(tlast), .TX_BYTE_O(tbyte),
    .ACT_PIN_I(pin_lvl), .ACT_PIN_O(pin_o), .ACT_PIN_OE_O(pin_oe));
  rf_reader_model u_rf_reader_model (.lclk_o(lclk), .sof_o(sof), .eof_o(eof),
    .valid_o(rvalid), .byte_o(rbyte), .tx_valid_i(tvalid), .tx_last_i(tlast),
    .tx_byte_i(tbyte), .pin_oe_i(pin_oe));
  // ==========================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= wd;
    sel <= 4'hf;
    // hold the request until ack; only the watchdog ends a missing answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction
  // one exchange: drop 1 = foreign uid, 2 = bad crc
  task automatic req(input logic [7:0] fl, input logic [7:0] cmd, input int b,
                     input logic [31:0] dd, input int drop);
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [7:0] code;
    logic [15:0] c;
    logic [63:0] u;
    logic prog;
    logic [3:0] st;
    int lo;
    code = 8'h00;
    u = uid_v ^ {63'h0, drop == 1};
    q = {fl, cmd};
    if (fl[FLG_ADDR]) for (int k = 0; k < 8; k++) q.push_back(u[8*k +: 8]);
    q.push_back(b[7:0]);
    q.push_back(b[15:8]);
    if (cmd == CMD_WRITE) for (int k = 0; k < 4; k++) q.push_back(dd[8*k +: 8]);
    c = crc(q) ^ {15'h0, drop == 2};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    if (!fl[FLG_PROT_EXT]) code = ERR_GENERIC;
    else if (b >= 64) code = ERR_NO_BLOCK;
    else if (cmd == CMD_READ && sec[b/32][2:1] == SEC_RD_PROT) code = ERR_RD_PROT;
    else if (cmd == CMD_WRITE && sec[b/32][0]) code = ERR_LOCKED;
    else if (cmd == CMD_WRITE && ctrl_v[1]) code = ERR_PROG;
    prog = cmd == CMD_WRITE && (code == 8'h00 || code == ERR_PROG);
    if (code != 8'h00) begin
      e = {RSP_ERR, code};
    end else begin
      e = {RSP_OK};
      if (cmd == CMD_READ && fl[FLG_OPTION]) e.push_back(sec[b/32]);
      if (cmd == CMD_READ) for (int k = 0; k < 4; k++) e.push_back(mem[b][8*k +: 8]);
      else if (drop == 0) mem[b] = dd;
    end
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    if (drop != 0) e.delete();
    u_rf_reader_model.req_q = q;
    u_rf_reader_model.xfer();
    check("pin_level", pin_o, 32'h0);
    check("reply_len", u_rf_reader_model.rsp_q.size(), e.size());
    foreach (e[i]) begin
      if (i < u_rf_reader_model.rsp_q.size()) begin
        check("reply_byte", u_rf_reader_model.rsp_q[i], e[i]);
      end
    end
    if (drop == 0) begin
      lo = (prog ? PROG_T : RESP_T) * 5 / 64 - 1;
      check("reply_wait", u_rf_reader_model.gap >= lo && u_rf_reader_model.gap <= lo + 4,
            1);
      check("pin", u_rf_reader_model.pin_seen,
            ctrl_v[0] ? {1'b0, prog, 3'b000} : 5'b11110);
      check("tx_last", u_rf_reader_model.last_seen, 2'h3);
    end
    // an error reply also counts as a read or write reply
    st = drop != 0 ? 4'h8 : {1'b0, code != 8'h00, cmd == CMD_WRITE, cmd == CMD_READ};
    rchk("status", ADDR_STATUS, {28'h0, st});
    check("irq", irq, |(st & mask_v));
    wb(1'b1, ADDR_STATUS, 32'hf);
    rchk("status_clr", ADDR_STATUS, 32'h0);
    check("irq_clr", irq, 1'b0);
  endtask
  // ==========================================================
  // tests
  initial begin
    void'($urandom(59));
    foreach (mem[i]) mem[i] = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rchk("reset_val", ra[i], rv[i]);
    uid_v = {$urandom, $urandom};
    wb(1'b1, ADDR_UID_LO, uid_v[31:0]);
    wb(1'b1, ADDR_UID_HI, uid_v[63:32]);
    sec = '{8'h18, 8'h07};
    wb(1'b1, ADDR_SEC, 32'h0000_0718);
    rchk("sec", ADDR_SEC, 32'h0000_0718);
    mask_v = 4'hf;
    wb(1'b1, ADDR_MASK, 32'hf);
    for (int i = 0; i < 4; i++) begin
      blk = $urandom % 32;
      d = $urandom;
      req(i[0] ? 8'h28 : 8'h08, CMD_WRITE, blk, d, 0);
      req(i[0] ? 8'h48 : 8'h68, CMD_READ, blk, 32'h0, 0);
    end
    req(8'h00, CMD_READ, 5, 32'h0, 0);
    req(8'h00, CMD_WRITE, 5, 32'h1, 0);
    req(8'h08, CMD_READ, 64, 32'h0, 0);
    req(8'h08, CMD_WRITE, 64, 32'h1, 0);
    req(8'h48, CMD_READ, 40, 32'h0, 0);
    req(8'h08, CMD_WRITE, 33, 32'h2, 0);
    ctrl_v = 2'h2;
    wb(1'b1, ADDR_CTRL, 32'h2);
    req(8'h08, CMD_WRITE, 7, 32'h3, 0);
    req(8'h28, CMD_READ, 6, 32'h0, 1);
    req(8'h08, CMD_WRITE, 6, 32'h4, 2);
    ctrl_v = 2'h1;
    wb(1'b1, ADDR_CTRL, 32'h1);
    mask_v = 4'h2;
    wb(1'b1, ADDR_MASK, 32'h2);
    req(8'h08, CMD_WRITE, 9, d, 0);
    req(8'h48, CMD_READ, 9, 32'h0, 0);
    req(8'h08, CMD_WRITE, 33, 32'h5, 0);
    tally_and_finish();
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule
